// *** include/lcd_ext_defs.svh ***
// constants for the extended instruction page decoder
// What this block does
// - Upper seven bits 0000001 decode as screen pairing; bit 0 picks pairing.
// - Pairing bit clear: columns join straight, 1 with 81 through 80 with 160.
// - Pairing bit set: columns join reversed, 1 with 160 through 80 with 81.
// - Orientation command bit 1: column data 1 to 80, or 80 down to 1.
// - Orientation bit 0, two lines: rows 1..16, icons 17,18; or reversed.
// - Single line: rows 1..8 or 8..1, icons always on row 17.
// - Upper five bits 00001 is icon control: bit2 icon-only, bit1 zero, bit0 direct.
// - Icon-only clear: characters and icons, mux 1:18 or 1:9, target from factor A.
// - Icon-only set: icons only at mux 1:2, target from factor B.
// - Direct mode set: generator off; the direct mode bit is driven out on o_bypass_supply and also gates o_gen_enable.
// - Upper six bits 000100 load thermal slope code; 00,10,01,11 map 0..3.
// - Thermal slope code resets to 00 and holds until rewritten.
// - Upper six bits 010000 load the pump stage code.
// - Stage code 00,01,10 enables one, two, three stages; 11 never written.
// - Bit 7 set: bit 6 picks factor A or B, bits 5..0 written.
// - Selected factor of zero switches the supply generator off.
// - Display off keeps the generator disabled whatever the factors hold.
// - Commands recognised only while the page-select bit is one.
// - Display off: outputs grounded, supply and bias generators off.
`ifndef LCD_EXT_DEFS_SVH
`define LCD_EXT_DEFS_SVH
`define LX_PAIR_OP 7'h01
`define LX_ORIENT_OP 6'h01
`define LX_ICON_OP 5'h01
`define LX_TEMP_OP 6'h04
`define LX_PUMP_OP 6'h10
`define LX_PUMP_BAD 2'h3
`define LX_TC_RST 2'h0
`define LX_PUMP_RST 2'h0
`define LX_STAGES_RST 2'h1
`define LX_FACTOR_RST 6'h00
`define LX_COLS 80
`define LX_ROWS_TWO 16
`define LX_ROWS_ONE 8
`define LX_ICON_ROW_A 17
`define LX_ICON_ROW_B 18
`endif

// *** include/lcd_ext_pkg.sv ***
// types shared by the extended page decoder
package lcd_ext_pkg;
  typedef enum logic [1:0] {
    MUX_1_18,
    MUX_1_9,
    MUX_1_2
  } mux_ratio_t;
endpackage

// *** include/supply_if.sv ***
// configuration and results between decoder and supply control
`timescale 1ns/1ps
interface supply_if;
  logic pictogram_only;
  logic bypass_supply;
  logic display_on;
  logic [5:0] factor_a;
  logic [5:0] factor_b;
  logic [1:0] pump_stage_cmd;
  logic gen_enable;
  logic [5:0] gen_target;
  logic [1:0] pump_stages;
  logic outputs_grounded;
  logic bias_enable;
  modport cfg (
    output pictogram_only, bypass_supply, display_on,
    output factor_a, factor_b, pump_stage_cmd,
    input gen_enable, gen_target, pump_stages, outputs_grounded, bias_enable
  );
  modport ctl (
    input pictogram_only, bypass_supply, display_on,
    input factor_a, factor_b, pump_stage_cmd,
    output gen_enable, gen_target, pump_stages, outputs_grounded, bias_enable
  );
endinterface

// *** hdl/supply_ctrl.sv ***
// supply generator enable, target and stage control
`timescale 1ns/1ps
`include "lcd_ext_defs.svh"
module supply_ctrl (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // configuration in, results out
  supply_if.ctl sif
);
  logic [5:0] sel_factor;

  // mode picks which factor drives the target
  assign sel_factor = sif.pictogram_only ? sif.factor_b : sif.factor_a;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sif.gen_enable <= 1'b0;
      sif.gen_target <= `LX_FACTOR_RST;
    end else begin
      sif.gen_target <= sel_factor;
      // off in direct mode, on zero factor, and while display is off
      sif.gen_enable <= sif.display_on && !sif.bypass_supply
                        && (sel_factor != 6'h00);
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sif.pump_stages <= `LX_STAGES_RST;
    end else if (sif.pump_stage_cmd != `LX_PUMP_BAD) begin
      sif.pump_stages <= sif.pump_stage_cmd + 2'h1;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sif.outputs_grounded <= 1'b1;
      sif.bias_enable <= 1'b0;
    end else begin
      sif.outputs_grounded <= !sif.display_on;
      sif.bias_enable <= sif.display_on;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  chk_gen_off_dark: assert property (
    !sif.display_on |=> !sif.gen_enable)
    else $error("generator on while display off");
  chk_gen_zero_off: assert property (
    (sel_factor == 6'h00) |=> !sif.gen_enable)
    else $error("generator on with zero factor");
  chk_ground_follow: assert property (
    $fell(sif.display_on) |=> sif.outputs_grounded && !sif.bias_enable)
    else $error("outputs not grounded after display off");
endmodule

// *** hdl/lcd_extended_config_decoder.sv ***
// extended page instruction decoder and configuration holder
`timescale 1ns/1ps
`include "lcd_ext_defs.svh"
module lcd_extended_config_decoder #(
  parameter int N_COLS = `LX_COLS,
  parameter int N_ROWS = `LX_ROWS_TWO
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // instruction byte from the host interface logic
  input wire logic i_instr_stb,
  input wire logic i_rs,
  input wire logic i_rw,
  input wire logic [7:0] i_instr,
  // state held by the basic page
  input wire logic i_page_ext,
  input wire logic i_display_on,
  input wire logic i_single_row_layout,
  input wire logic i_low_mux,
  // mapping queries from the display scan
  input wire logic [6:0] i_col,
  input wire logic [4:0] i_row_slot,
  // held configuration
  output logic o_pair_reversed,
  output logic o_col_reversed,
  output logic o_row_reversed,
  output logic o_pictogram_only,
  output logic o_bypass_supply,
  output logic [1:0] o_thermal_slope_sel,
  output logic [1:0] o_thermal_coeff,
  output logic [1:0] o_pump_stage_cmd,
  output logic [5:0] o_factor_a,
  output logic [5:0] o_factor_b,
  output lcd_ext_pkg::mux_ratio_t o_mux_ratio,
  output logic o_cmd_reject,
  // mapping answers
  output logic [7:0] o_col_partner,
  output logic [6:0] o_col_drive,
  output logic [4:0] o_row_drive,
  // supply control
  output logic o_gen_enable,
  output logic [5:0] o_gen_target,
  output logic [1:0] o_pump_stages,
  output logic o_outputs_grounded,
  output logic o_bias_enable
);

  if (N_COLS != `LX_COLS || N_ROWS != `LX_ROWS_TWO) begin : g_chk
    $error("column and row counts are fixed by the pairing scheme");
  end

  localparam logic [7:0] COLS8 = 8'(N_COLS);
  localparam logic [4:0] ROWS5 = 5'(N_ROWS);
  localparam logic [4:0] ROWS1 = 5'(`LX_ROWS_ONE);
  localparam logic [4:0] ICON_A = 5'(`LX_ICON_ROW_A);
  localparam logic [4:0] ICON_B = 5'(`LX_ICON_ROW_B);

  // instruction qualification

  logic wr;
  logic is_factor;
  logic is_pair;
  logic is_orient;
  logic is_icon;
  logic is_temp;
  logic is_pump;
  logic bad_icon;
  logic bad_pump;

  // only instruction writes on the extended page count
  assign wr = i_instr_stb && !i_rs && !i_rw && i_page_ext;

  assign is_factor = wr && i_instr[7];
  assign is_pair = wr && (i_instr[7:1] == `LX_PAIR_OP);
  assign is_orient = wr && (i_instr[7:2] == `LX_ORIENT_OP);
  assign is_icon = wr && (i_instr[7:3] == `LX_ICON_OP);
  assign is_temp = wr && (i_instr[7:2] == `LX_TEMP_OP);
  assign is_pump = wr && (i_instr[7:2] == `LX_PUMP_OP);

  // illegal fixed bit or forbidden stage code is not taken
  assign bad_icon = is_icon && i_instr[1];
  assign bad_pump = is_pump && (i_instr[1:0] == `LX_PUMP_BAD);

  // configuration fields, each written only by its own command

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_pair_reversed <= 1'b0;
    end else if (is_pair) begin
      o_pair_reversed <= i_instr[0];
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_col_reversed <= 1'b0;
      o_row_reversed <= 1'b0;
    end else if (is_orient) begin
      o_col_reversed <= i_instr[1];
      o_row_reversed <= i_instr[0];
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_pictogram_only <= 1'b0;
      o_bypass_supply <= 1'b0;
    end else if (is_icon && !bad_icon) begin
      o_pictogram_only <= i_instr[2];
      o_bypass_supply <= i_instr[0];
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_thermal_slope_sel <= `LX_TC_RST;
      o_thermal_coeff <= `LX_TC_RST;
    end else if (is_temp) begin
      o_thermal_slope_sel <= i_instr[1:0];
      // code bits are weighted low first
      o_thermal_coeff <= {i_instr[0], i_instr[1]};
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_pump_stage_cmd <= `LX_PUMP_RST;
    end else if (is_pump && !bad_pump) begin
      o_pump_stage_cmd <= i_instr[1:0];
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_factor_a <= `LX_FACTOR_RST;
      o_factor_b <= `LX_FACTOR_RST;
    end else if (is_factor) begin
      if (i_instr[6]) begin
        o_factor_b <= i_instr[5:0];
      end else begin
        o_factor_a <= i_instr[5:0];
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_cmd_reject <= 1'b0;
    end else begin
      o_cmd_reject <= bad_icon || bad_pump;
    end
  end

  // multiplex ratio follows the drive mode

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_mux_ratio <= lcd_ext_pkg::MUX_1_18;
    end else if (o_pictogram_only) begin
      o_mux_ratio <= lcd_ext_pkg::MUX_1_2;
    end else if (i_low_mux) begin
      o_mux_ratio <= lcd_ext_pkg::MUX_1_9;
    end else begin
      o_mux_ratio <= lcd_ext_pkg::MUX_1_18;
    end
  end

  // column pairing and column order; zero marks an invalid query

  logic col_ok;
  logic [7:0] col8;

  assign col_ok = (i_col != 7'h00) && ({1'b0, i_col} <= COLS8);
  assign col8 = {1'b0, i_col};

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_col_partner <= 8'h00;
    end else if (!col_ok) begin
      o_col_partner <= 8'h00;
    end else if (o_pair_reversed) begin
      o_col_partner <= COLS8 + COLS8 + 8'h01 - col8;
    end else begin
      o_col_partner <= col8 + COLS8;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_col_drive <= 7'h00;
    end else if (!col_ok) begin
      o_col_drive <= 7'h00;
    end else if (o_col_reversed) begin
      o_col_drive <= 7'(COLS8 + 8'h01 - col8);
    end else begin
      o_col_drive <= i_col;
    end
  end

  // row order: slots below the row count are text, then two icon slots (single line: slot 16 only)

  logic [4:0] row_next;

  always_comb begin
    row_next = 5'h00;
    if (i_single_row_layout) begin
      if (i_row_slot < ROWS1) begin
        row_next = o_row_reversed ? ROWS1 - i_row_slot
                                  : i_row_slot + 5'h01;
      end else if (i_row_slot == ROWS5) begin
        row_next = ICON_A;
      end
    end else begin
      if (i_row_slot < ROWS5) begin
        row_next = o_row_reversed ? ROWS5 - i_row_slot
                                  : i_row_slot + 5'h01;
      end else if (i_row_slot == ROWS5) begin
        row_next = o_row_reversed ? ICON_B : ICON_A;
      end else if (i_row_slot == ROWS5 + 5'h01) begin
        row_next = o_row_reversed ? ICON_A : ICON_B;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_row_drive <= 5'h00;
    end else begin
      o_row_drive <= row_next;
    end
  end

  // supply control

  supply_if sif ();

  assign sif.pictogram_only = o_pictogram_only;
  assign sif.bypass_supply = o_bypass_supply;
  assign sif.display_on = i_display_on;
  assign sif.factor_a = o_factor_a;
  assign sif.factor_b = o_factor_b;
  assign sif.pump_stage_cmd = o_pump_stage_cmd;

  supply_ctrl u_supply (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .sif(sif.ctl)
  );

  assign o_gen_enable = sif.gen_enable;
  assign o_gen_target = sif.gen_target;
  assign o_pump_stages = sif.pump_stages;
  assign o_outputs_grounded = sif.outputs_grounded;
  assign o_bias_enable = sif.bias_enable;

  // checks

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  sequence s_factor_write(logic sel);
    wr && i_instr[7] && (i_instr[6] == sel);
  endsequence

  chk_page_gate: assert property (
    (i_instr_stb && !i_page_ext) |=> $stable(o_factor_a) && $stable(o_factor_b)
      && $stable(o_thermal_slope_sel) && $stable(o_pump_stage_cmd))
    else $error("field changed outside extended page");
  chk_data_ignored: assert property (
    (i_instr_stb && (i_rs || i_rw)) |=> $stable(o_pair_reversed)
      && $stable(o_col_reversed) && $stable(o_pictogram_only))
    else $error("data access changed configuration");
  chk_factor_a_load: assert property (
    s_factor_write(1'b0) |=> (o_factor_a == $past(i_instr[5:0]))
      && $stable(o_factor_b))
    else $error("factor A write wrong");
  chk_factor_b_load: assert property (
    s_factor_write(1'b1) |=> (o_factor_b == $past(i_instr[5:0]))
      && $stable(o_factor_a))
    else $error("factor B write wrong");
  chk_tc_map: assert property (
    is_temp |=> o_thermal_coeff == {o_thermal_slope_sel[0], o_thermal_slope_sel[1]})
    else $error("thermal coefficient mapping wrong");
  chk_pump_legal: assert property (
    bad_pump |=> $stable(o_pump_stage_cmd) && o_cmd_reject)
    else $error("forbidden stage code taken");
  chk_pair_straight: assert property (
    (col_ok && !o_pair_reversed) |=> o_col_partner == $past(col8) + COLS8)
    else $error("straight pairing wrong");
  chk_pair_mirror: assert property (
    (col_ok && o_pair_reversed && !is_pair) |=>
      o_col_partner + $past(col8) == 8'(2 * N_COLS + 1))
    else $error("mirrored pairing wrong");
  chk_icon_mux: assert property (
    o_pictogram_only |=> o_mux_ratio == lcd_ext_pkg::MUX_1_2)
    else $error("icon mode mux wrong");
  chk_target_sel: assert property (
    o_pictogram_only |=> o_gen_target == $past(o_factor_b))
    else $error("icon target not from factor B");
  chk_bypass_off: assert property (
    o_bypass_supply |=> !o_gen_enable)
    else $error("generator on in direct mode");
  chk_single_icon: assert property (
    (i_single_row_layout && i_row_slot == ROWS5) |=> o_row_drive == ICON_A)
    else $error("single line icon row wrong");
  chk_pair_load: assert property (
    is_pair |=> o_pair_reversed == $past(i_instr[0]))
    else $error("pairing bit not loaded");
  chk_col_straight: assert property (
    (col_ok && !o_col_reversed) |=> o_col_drive == $past(i_col))
    else $error("straight column order wrong");
  chk_col_mirror: assert property (
    (col_ok && o_col_reversed) |=> o_col_drive + $past(i_col) == 7'(N_COLS + 1))
    else $error("mirrored column order wrong");
  chk_col_invalid: assert property (
    !col_ok |=> (o_col_drive == 7'h00) && (o_col_partner == 8'h00))
    else $error("invalid column not answered with zero");
  chk_row_straight: assert property (
    (!i_single_row_layout && i_row_slot < ROWS5 && !o_row_reversed) |=>
      o_row_drive == $past(i_row_slot) + 5'h01)
    else $error("straight row order wrong");
  chk_row_mirror: assert property (
    (!i_single_row_layout && i_row_slot < ROWS5 && o_row_reversed) |=>
      o_row_drive + $past(i_row_slot) == ROWS5)
    else $error("mirrored row order wrong");
  chk_icon_rows: assert property (
    (!i_single_row_layout && i_row_slot == ROWS5) |=>
      o_row_drive == ($past(o_row_reversed) ? ICON_B : ICON_A))
    else $error("two line icon row wrong");
  chk_single_text: assert property (
    (i_single_row_layout && i_row_slot < ROWS1) |=>
      (o_row_drive != 5'h00) && (o_row_drive <= ROWS1))
    else $error("single line text row out of range");
  chk_icon_load: assert property (
    (is_icon && !bad_icon) |=> (o_pictogram_only == $past(i_instr[2]))
      && (o_bypass_supply == $past(i_instr[0])))
    else $error("icon control not loaded");
  chk_icon_refuse: assert property (
    bad_icon |=> $stable(o_pictogram_only) && $stable(o_bypass_supply) && o_cmd_reject)
    else $error("icon command with fixed bit set taken");
  chk_pump_load: assert property (
    (is_pump && !bad_pump) |=> o_pump_stage_cmd == $past(i_instr[1:0]))
    else $error("stage code not loaded");
  chk_char_target: assert property (
    !o_pictogram_only |=> o_gen_target == $past(o_factor_a))
    else $error("character target not from factor A");
  chk_slope_hold: assert property (
    !is_temp |=> $stable(o_thermal_slope_sel))
    else $error("thermal slope changed without command");
endmodule

// *** dv/lcd_host_model.sv ***
// host model that issues instruction bytes to the decoder
`timescale 1ns/1ps
module lcd_host_model (
  // clock
  input wire logic i_clk,
  // instruction port towards the decoder
  output logic o_stb,
  output logic o_rs,
  output logic o_rw,
  output logic o_page,
  output logic [7:0] o_instr
);
  initial begin
    o_stb = 1'b0;
    o_rs = 1'b1;
    o_rw = 1'b1;
    o_page = 1'b0;
    o_instr = 8'hff;
  end

  // page select changes only between bytes
  task automatic set_page(input logic p);
    @(posedge i_clk);
    #1;
    o_page = p;
  endtask

  // one strobed byte, bus lines left inverted once released
  task automatic send(input logic [7:0] b, input logic rs, input logic rw);
    @(posedge i_clk);
    #1;
    o_stb = 1'b1;
    o_rs = rs;
    o_rw = rw;
    o_instr = b;
    @(posedge i_clk);
    #1;
    o_stb = 1'b0;
    o_rs = 1'b1;
    o_rw = 1'b1;
    o_instr = ~b;
  endtask
endmodule

// *** dv/test_lcd_extended_config_decoder.sv ***
// self-checking bench for the extended page decoder
`timescale 1ns/1ps
module test_lcd_extended_config_decoder;
  logic i_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic stb, rs, rw, page;
  logic [7:0] instr;
  logic disp_on = 1'b1;
  logic single = 1'b0;
  logic low_mux = 1'b0;
  logic [6:0] col = 7'h01;
  logic [4:0] slot = 5'h00;
  logic pair_rev, col_rev, row_rev, pict, bypass, rej, gen_en, grounded, bias;
  logic [1:0] slope, coeff, pump_cmd, stages, c;
  logic [5:0] fa, fb, target;
  lcd_ext_pkg::mux_ratio_t mux;
  logic [7:0] partner;
  logic [6:0] cdrv;
  logic [4:0] rdrv;
  int n_errors = 0;
  int samples_checked = 0;
  int cycles = 0;

  always #5 i_clk = ~i_clk;

  lcd_host_model i_host (.i_clk(i_clk), .o_stb(stb), .o_rs(rs), .o_rw(rw), .o_page(page),
    .o_instr(instr));

  lcd_extended_config_decoder i_dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_instr_stb(stb),
    .i_rs(rs), .i_rw(rw), .i_instr(instr), .i_page_ext(page), .i_display_on(disp_on),
    .i_single_row_layout(single), .i_low_mux(low_mux), .i_col(col), .i_row_slot(slot),
    .o_pair_reversed(pair_rev), .o_col_reversed(col_rev), .o_row_reversed(row_rev),
    .o_pictogram_only(pict), .o_bypass_supply(bypass), .o_thermal_slope_sel(slope),
    .o_thermal_coeff(coeff), .o_pump_stage_cmd(pump_cmd), .o_factor_a(fa), .o_factor_b(fb),
    .o_mux_ratio(mux), .o_cmd_reject(rej), .o_col_partner(partner), .o_col_drive(cdrv),
    .o_row_drive(rdrv), .o_gen_enable(gen_en), .o_gen_target(target),
    .o_pump_stages(stages), .o_outputs_grounded(grounded), .o_bias_enable(bias));

  task automatic close_out();
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // run should need about 120 cycles
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      $display("unexpected at %0t: timeout", $time);
      close_out();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  task automatic snd(input logic [7:0] b);
    i_host.send(b, 1'b0, 1'b0);
    wt(1);
  endtask

  // refusal pulse stands for the one cycle after the byte
  task automatic snd_rej(input logic [7:0] b);
    i_host.send(b, 1'b0, 1'b0);
    chk(rej, 1'b1, "reject pulse");
    wt(1);
    chk(rej, 1'b0, "reject pulse ends");
  endtask

  task automatic q(input logic [6:0] cq, input logic [4:0] s);
    @(posedge i_clk);
    #1;
    col = cq;
    slot = s;
    wt(1);
  endtask

  task automatic qp(input logic [6:0] cq, input logic [7:0] ep);
    q(cq, 5'h00);
    chk(partner, ep, "partner column");
  endtask

  task automatic qr(input logic [6:0] cq, input logic [4:0] s, input logic [6:0] ec,
      input logic [4:0] er);
    q(cq, s);
    chk(cdrv, ec, "driven column");
    chk(rdrv, er, "driven row");
  endtask

  task automatic t_reset();
    chk(slope, 2'h0, "slope default");
    chk(coeff, 2'h0, "coeff default");
    chk(fa, 6'h00, "factor a reset");
    chk(gen_en, 1'b0, "generator at reset");
  endtask

  task automatic t_pair();
    snd(8'h03);
    chk(pair_rev, 1'b1, "pairing set");
    qp(7'd1, 8'd160);
    qp(7'd80, 8'd81);
    snd(8'h02);
    chk(pair_rev, 1'b0, "pairing clear");
    qp(7'd1, 8'd81);
    qp(7'd80, 8'd160);
    qp(7'd0, 8'd0);
    qp(7'd81, 8'd0);
  endtask

  task automatic t_orient();
    snd(8'h06);
    chk(col_rev, 1'b1, "column order");
    qr(7'd1, 5'd0, 7'd80, 5'd1);
    qr(7'd80, 5'd17, 7'd1, 5'd18);
    snd(8'h05);
    chk(row_rev, 1'b1, "row order");
    qr(7'd1, 5'd0, 7'd1, 5'd16);
    qr(7'd2, 5'd16, 7'd2, 5'd18);
    qr(7'd3, 5'd17, 7'd3, 5'd17);
    single = 1'b1;
    qr(7'd1, 5'd0, 7'd1, 5'd8);
    qr(7'd1, 5'd16, 7'd1, 5'd17);
    snd(8'h04);
    qr(7'd1, 5'd7, 7'd1, 5'd8);
    qr(7'd1, 5'd16, 7'd1, 5'd17);
    single = 1'b0;
  endtask

  task automatic t_factor();
    snd(8'h85);
    chk(fa, 6'h05, "factor a");
    chk(fb, 6'h00, "factor b untouched");
    chk(target, 6'h05, "target from a");
    chk(gen_en, 1'b1, "generator on");
    snd(8'hc9);
    chk(fb, 6'h09, "factor b");
    chk(target, 6'h05, "target still a");
    snd(8'h80);
    chk(gen_en, 1'b0, "zero factor");
    snd(8'h85);
    disp_on = 1'b0;
    wt(2);
    chk(gen_en, 1'b0, "display off gen");
    chk(grounded, 1'b1, "display off ground");
    chk(bias, 1'b0, "display off bias");
    disp_on = 1'b1;
    wt(2);
    chk(gen_en, 1'b1, "display back on");
  endtask

  task automatic t_icon();
    low_mux = 1'b1;
    snd(8'h08);
    chk(mux, lcd_ext_pkg::MUX_1_9, "mux 1:9");
    low_mux = 1'b0;
    wt(2);
    chk(mux, lcd_ext_pkg::MUX_1_18, "mux 1:18");
    snd(8'h0c);
    chk(pict, 1'b1, "icon only");
    chk(mux, lcd_ext_pkg::MUX_1_2, "mux 1:2");
    chk(target, 6'h09, "target from b");
    snd_rej(8'h0a);
    chk(pict, 1'b1, "bad icon cmd kept");
    snd(8'h09);
    chk(bypass, 1'b1, "direct mode");
    chk(gen_en, 1'b0, "direct gen off");
    snd(8'h08);
    chk(gen_en, 1'b1, "direct off");
  endtask

  task automatic t_codes();
    for (int i = 0; i < 4; i++) begin
      c = i[1:0];
      snd({6'h04, c});
      chk(slope, c, "slope code");
      chk(coeff, {c[0], c[1]}, "coeff index");
    end
    for (int i = 0; i < 3; i++) begin
      c = i[1:0];
      snd({6'h10, c});
      chk(pump_cmd, c, "stage code");
      chk(stages, c + 2'h1, "stage count");
    end
    snd_rej(8'h43);
    chk(pump_cmd, 2'h2, "bad stage kept");
  endtask

  task automatic t_refuse();
    i_host.set_page(1'b0);
    snd(8'h81);
    chk(fa, 6'h05, "basic page");
    i_host.set_page(1'b1);
    i_host.send(8'h81, 1'b1, 1'b0);
    wt(1);
    chk(fa, 6'h05, "data access");
    i_host.send(8'h81, 1'b0, 1'b1);
    wt(1);
    chk(fa, 6'h05, "read access");
  endtask

  initial begin
    repeat (5) @(posedge i_clk);
    #1;
    i_nrst = 1'b1;
    t_reset();
    i_host.set_page(1'b1);
    t_pair();
    t_orient();
    t_factor();
    t_icon();
    t_codes();
    t_refuse();
    close_out();
  end
endmodule
